// [rtl/pattern_readout_regs.svh]
// Constants for the calibration-pattern readout block.
// Assumes a 25 ns system clock; included by bare name.
`ifndef PATTERN_READOUT_REGS_SVH
`define PATTERN_READOUT_REGS_SVH

// ==========================================================================
// Mode register 3 fields and command address bits
`define MR3_BANK 3'h3
`define MR3_ENABLE_BIT 2
`define MR3_LOC_LSB 0
`define ADDR_AP_BIT 10
`define ADDR_BC_BIT 12
`define ADDR_NIBBLE_BIT 2

// ==========================================================================
// Pattern contents, beat 0 in bit 0
`define PATTERN_LOC0 8'haa
`define PATTERN_RFU 8'h00

// ==========================================================================
// Timing
`define SYS_CLK_PERIOD_PS 25000
`define REFRESH_CYCLE_TIME_PS 110000
`define REFRESH_CYCLES ((`REFRESH_CYCLE_TIME_PS + `SYS_CLK_PERIOD_PS - 1) / `SYS_CLK_PERIOD_PS)
`define ROW_BUSY_CYCLES 2
`define ZQ_SHORT_CYCLES 64
`define WR_START_OFFSET_LONG 4
`define WR_START_OFFSET_CHOP 2
`define BEATS_FULL 8
`define BEATS_CHOP 4

`endif

// [rtl/pattern_readout_pkg.sv]
// Types shared by the pattern readout command and link sides.
// Assumes the constants header is on the include path.
package pattern_readout_pkg;

    // ======================================================================
    // Commands
    typedef enum logic [2:0] {
        CMD_NOP = 3'h0, CMD_MRS = 3'h1, CMD_ACT = 3'h2, CMD_PRE = 3'h3,
        CMD_REF = 3'h4, CMD_RD = 3'h5, CMD_WR = 3'h6, CMD_ZQS = 3'h7
    } cmd_op_t;

    typedef struct packed {
        logic valid;
        cmd_op_t op;
        logic [2:0] bank;
        logic [13:0] addr;
    } cmd_t;

    typedef enum logic [1:0] {
        BURST_FIXED_EIGHT = 2'h0,
        BURST_FIXED_CHOP = 2'h1,
        BURST_ON_THE_FLY = 2'h2
    } burst_mode_t;

    // ======================================================================
    // Burst request crossing into the link domain
    typedef struct packed {
        logic [7:0] pattern;
        logic chop;
        logic upper_nibble;
    } burst_desc_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00, LINK_BURST = 2'b01, LINK_DONE = 2'b11
    } link_state_e_t;

    typedef struct packed {
        logic pattern_en;
        logic [1:0] loc;
        logic cke_s1;
        logic cke_s2;
        logic ack_s1;
        logic ack_s2;
        logic req_tgl;
        burst_desc_t desc;
        logic [5:0] wr_cnt;
        logic [3:0] busy_cnt;
        logic [6:0] zq_cnt;
        logic array_rd;
        logic array_wr;
        logic precharge;
        logic write_start;
        logic illegal;
        logic refused;
        logic low_power;
    } sys_state_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic ack_tgl;
        link_state_e_t state;
        logic [2:0] beat;
        logic [3:0] left;
        burst_desc_t desc;
        logic [15:0] dq;
        logic dq_oe;
        logic strobe;
        logic strobe_oe;
    } link_state_t;

endpackage

// [rtl/pattern_burst_driver.sv]
// Link-side driver: plays one pattern burst per request toggle.
// Assumes desc_i is held stable while req_tgl_i differs from ack_tgl_o.
`timescale 1ns/1ps
`default_nettype none

`include "pattern_readout_regs.svh"

module pattern_burst_driver
    import pattern_readout_pkg::*;
#(
    parameter bit REPEAT_PATTERN = 1'b1
) (
    input wire logic clk_link_i,
    input wire logic sys_rst_i,
    input wire logic req_tgl_i,
    input wire burst_desc_t desc_i,
    output logic ack_tgl_o,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic strobe_o,
    output logic strobe_oe_o
);

    link_state_t r, nxt;
    logic bit_now;
    logic [7:0] lane;

    // ======================================================================
    // Next state
    always_comb begin
        nxt = r;
        nxt.rst_s1 = sys_rst_i;
        nxt.rst_s2 = r.rst_s1;
        nxt.req_s1 = req_tgl_i;
        nxt.req_s2 = r.req_s1;
        bit_now = r.desc.pattern[r.beat];
        // Unused lines repeat the bit or drive zero
        lane = REPEAT_PATTERN ? {8{bit_now}} : {7'h00, bit_now};
        case (r.state)
            LINK_IDLE: begin
                nxt.dq_oe = 1'b0;
                nxt.strobe_oe = 1'b0;
                nxt.strobe = 1'b0;
                if (r.req_s2 != r.req_seen) begin
                    nxt.req_seen = r.req_s2;
                    nxt.desc = desc_i;
                    // Chop picks nibble 0-3 or 4-7
                    nxt.beat = desc_i.upper_nibble ? 3'h4 : 3'h0;
                    nxt.left = desc_i.chop ? 4'(`BEATS_CHOP) : 4'(`BEATS_FULL);
                    nxt.state = LINK_BURST;
                end
            end
            LINK_BURST: begin
                nxt.dq = {lane, lane};
                nxt.dq_oe = 1'b1;
                nxt.strobe_oe = 1'b1;
                nxt.strobe = ~r.strobe;
                nxt.beat = r.beat + 3'h1;
                nxt.left = r.left - 4'h1;
                if (r.left == 4'h1) begin
                    nxt.state = LINK_DONE;
                end
            end
            LINK_DONE: begin
                nxt.dq_oe = 1'b0;
                nxt.strobe_oe = 1'b0;
                nxt.strobe = 1'b0;
                nxt.ack_tgl = ~r.ack_tgl;
                nxt.state = LINK_IDLE;
            end
            default: nxt.state = LINK_IDLE;
        endcase
        if (r.rst_s2) begin
            nxt = '0;
            nxt.rst_s1 = sys_rst_i;
            nxt.rst_s2 = r.rst_s1;
        end
    end

    always_ff @(posedge clk_link_i) begin
        r <= nxt;
    end

    assign ack_tgl_o = r.ack_tgl;
    assign dq_o = r.dq;
    assign dq_oe_o = r.dq_oe;
    assign strobe_o = r.strobe;
    assign strobe_oe_o = r.strobe_oe;

    // ======================================================================
    // Checks
    a_lane_copy: assert property (@(posedge clk_link_i) disable iff (r.rst_s2)
        dq_oe_o |-> dq_o[15:8] == dq_o[7:0])
        else $error("byte lanes differ during pattern burst");

    a_loc0_alternates: assert property (@(posedge clk_link_i)
        disable iff (r.rst_s2)
        (dq_oe_o && r.desc.pattern == `PATTERN_LOC0) ##1 dq_oe_o
        |-> dq_o[0] != $past(dq_o[0]))
        else $error("location zero pattern does not alternate");

endmodule // pattern_burst_driver

`default_nettype wire

// [rtl/ddr3_calibration_pattern_readout.sv]
// Command side of the calibration-pattern readout mode.
// Assumes commands come from logic on clk_sys_i; the data pins run on
// clk_link_i; cke_i arrives from a pin.
//
// Operation
// - Mode register three bit two enables mode
// - Reads served from pattern register in mode
// - Location select picks returned pattern
// - Auto-precharge read acts as plain read
// - Reset still honoured in pattern mode
// - Bit two clear gives normal array access
// - Write starts four or two after latency
// - Device finishes busy work before low power
// - Short calibration completes within 64 cycles
// - Lowest line per lane carries pattern bit
// - Location zero returns alternating zero, one
`timescale 1ns/1ps
`default_nettype none

`include "pattern_readout_regs.svh"

module ddr3_calibration_pattern_readout
    import pattern_readout_pkg::*;
#(
    parameter bit REPEAT_PATTERN = 1'b1,
    parameter int WL_WIDTH = 5
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_link_i,
    input wire cmd_t cmd_i,
    input wire logic cke_i,
    input wire logic [WL_WIDTH-1:0] write_latency_cycles_i,
    input wire burst_mode_t burst_mode_i,
    output logic pattern_mode_o,
    output logic [1:0] pattern_location_select_o,
    output logic array_read_o,
    output logic array_write_o,
    output logic precharge_o,
    output logic write_start_o,
    output logic cmd_illegal_o,
    output logic read_refused_o,
    output logic refresh_busy_o,
    output logic zq_busy_o,
    output logic low_power_o,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic strobe_o,
    output logic strobe_oe_o
);

    // ======================================================================
    // Elaboration checks
    if (WL_WIDTH < 1 || WL_WIDTH > 5) begin : g_bad_wl
        $error("WL_WIDTH must lie in 1..5 to fit the write counter");
    end

    sys_state_t r, nxt;
    logic ack_tgl;
    logic pending;
    logic is_mr3;
    logic chop;
    logic [5:0] wr_offset;
    logic [7:0] pattern_sel;

    // ======================================================================
    // Pattern lookup
    function automatic logic [7:0] pattern_of(input logic [1:0] loc);
        case (loc)
            2'h0: pattern_of = `PATTERN_LOC0;
            default: pattern_of = `PATTERN_RFU;
        endcase
    endfunction

    // ======================================================================
    // Next state
    always_comb begin
        nxt = r;
        nxt.array_rd = 1'b0;
        nxt.array_wr = 1'b0;
        nxt.precharge = 1'b0;
        nxt.illegal = 1'b0;
        nxt.refused = 1'b0;
        nxt.cke_s1 = cke_i;
        nxt.cke_s2 = r.cke_s1;
        nxt.ack_s1 = ack_tgl;
        nxt.ack_s2 = r.ack_s1;
        pending = r.req_tgl != r.ack_s2;
        is_mr3 = cmd_i.bank == `MR3_BANK;
        chop = (burst_mode_i == BURST_FIXED_CHOP) ||
               (burst_mode_i == BURST_ON_THE_FLY && !cmd_i.addr[`ADDR_BC_BIT]);
        wr_offset = (burst_mode_i == BURST_FIXED_CHOP) ?
                    6'(`WR_START_OFFSET_CHOP) : 6'(`WR_START_OFFSET_LONG);
        pattern_sel = pattern_of(r.loc);
        nxt.write_start = r.wr_cnt == 6'h1;
        if (r.wr_cnt != 6'h0) begin
            nxt.wr_cnt = r.wr_cnt - 6'h1;
        end
        if (r.busy_cnt != 4'h0) begin
            nxt.busy_cnt = r.busy_cnt - 4'h1;
        end
        if (r.zq_cnt != 7'h0) begin
            nxt.zq_cnt = r.zq_cnt - 7'h1;
        end
        if (cmd_i.valid) begin
            case (cmd_i.op)
                CMD_MRS: begin
                    if (is_mr3) begin
                        nxt.pattern_en = cmd_i.addr[`MR3_ENABLE_BIT];
                        nxt.loc = cmd_i.addr[`MR3_LOC_LSB +: 2];
                    end else if (r.pattern_en) begin
                        nxt.illegal = 1'b1;
                    end
                end
                CMD_RD: begin
                    if (r.pattern_en) begin // No precharge here
                        // One burst in flight; a read during it is dropped
                        if (pending) begin
                            nxt.refused = 1'b1;
                        end else begin
                            nxt.desc.pattern = pattern_sel;
                            nxt.desc.chop = chop;
                            nxt.desc.upper_nibble =
                                chop & cmd_i.addr[`ADDR_NIBBLE_BIT];
                            nxt.req_tgl = ~r.req_tgl;
                        end
                    end else begin
                        nxt.array_rd = 1'b1;
                        nxt.precharge = cmd_i.addr[`ADDR_AP_BIT];
                    end
                end
                CMD_WR: begin
                    if (r.pattern_en) begin
                        nxt.illegal = 1'b1;
                    end else begin
                        nxt.array_wr = 1'b1;
                        nxt.precharge = cmd_i.addr[`ADDR_AP_BIT];
                        nxt.wr_cnt = 6'(write_latency_cycles_i) + wr_offset
                                     - 6'h1;
                    end
                end
                CMD_ACT, CMD_PRE: begin
                    if (r.pattern_en) begin
                        nxt.illegal = 1'b1;
                    end else if (r.busy_cnt < 4'(`ROW_BUSY_CYCLES)) begin
                        nxt.busy_cnt = 4'(`ROW_BUSY_CYCLES);
                    end
                end
                CMD_REF: begin
                    if (r.pattern_en) begin
                        nxt.illegal = 1'b1;
                    end else begin
                        nxt.busy_cnt = 4'(`REFRESH_CYCLES);
                    end
                end
                CMD_ZQS: begin
                    if (r.pattern_en) begin
                        nxt.illegal = 1'b1;
                    end else begin
                        nxt.zq_cnt = 7'(`ZQ_SHORT_CYCLES);
                    end
                end
                default: nxt.illegal = 1'b0;
            endcase
        end
        // Clock enable low is flagged but not acted on in pattern mode
        if (r.pattern_en && !r.cke_s2) begin
            nxt.illegal = 1'b1;
        end
        nxt.low_power = !r.cke_s2 && !r.pattern_en && r.busy_cnt == 4'h0 &&
                        r.zq_cnt == 7'h0;
        if (sys_rst_i) begin
            nxt = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        r <= nxt;
    end

    // ======================================================================
    // Link side
    pattern_burst_driver #(
        .REPEAT_PATTERN(REPEAT_PATTERN)
    ) u_burst (
        .clk_link_i(clk_link_i),
        .sys_rst_i(sys_rst_i),
        .req_tgl_i(r.req_tgl),
        .desc_i(r.desc),
        .ack_tgl_o(ack_tgl),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o),
        .strobe_o(strobe_o),
        .strobe_oe_o(strobe_oe_o)
    );

    assign pattern_mode_o = r.pattern_en;
    assign pattern_location_select_o = r.loc;
    assign array_read_o = r.array_rd;
    assign array_write_o = r.array_wr;
    assign precharge_o = r.precharge;
    assign write_start_o = r.write_start;
    assign cmd_illegal_o = r.illegal;
    assign read_refused_o = r.refused;
    assign refresh_busy_o = r.busy_cnt != 4'h0;
    assign zq_busy_o = r.zq_cnt != 7'h0;
    assign low_power_o = r.low_power;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    logic [7:0] h_since_wr;
    logic [7:0] h_expect;
    always_ff @(posedge clk_sys_i) begin
        if (cmd_i.valid && cmd_i.op == CMD_WR && !r.pattern_en) begin
            h_since_wr <= 8'h01;
            h_expect <= 8'(write_latency_cycles_i) + 8'(wr_offset);
        end else begin
            h_since_wr <= h_since_wr + 8'h01;
        end
    end

    sequence s_mr3_write;
        cmd_i.valid && cmd_i.op == CMD_MRS && cmd_i.bank == `MR3_BANK;
    endsequence
    sequence s_pattern_read;
        r.pattern_en && cmd_i.valid && cmd_i.op == CMD_RD;
    endsequence

    a_mode_enable: assert property (s_mr3_write and
        cmd_i.addr[`MR3_ENABLE_BIT] |=> pattern_mode_o)
        else $error("pattern mode not entered");
    a_mode_disable: assert property ((s_mr3_write and
        !cmd_i.addr[`MR3_ENABLE_BIT]) ##1 (!cmd_i.valid)[*4] ##1
        (cmd_i.valid && cmd_i.op == CMD_RD) |=> array_read_o)
        else $error("read after disable did not reach array");
    a_loc_capture: assert property (s_mr3_write |=>
        pattern_location_select_o == $past(cmd_i.addr[1:0]))
        else $error("location select not captured");
    a_read_redirect: assert property (s_pattern_read |=>
        !array_read_o && (read_refused_o || r.req_tgl != $past(r.req_tgl)))
        else $error("pattern read neither redirected nor refused");
    a_rda_plain: assert property (s_pattern_read |=> !precharge_o)
        else $error("precharge issued in pattern mode");
    a_reset_exit: assert property (disable iff (1'b0)
        sys_rst_i |=> !pattern_mode_o && !write_start_o)
        else $error("reset did not clear pattern mode");
    a_write_start: assert property (write_start_o |->
        h_since_wr == h_expect)
        else $error("internal write start at wrong cycle");
    a_refresh_busy: assert property (cmd_i.valid && cmd_i.op == CMD_REF &&
        !r.pattern_en |=> refresh_busy_o[*5])
        else $error("refresh busy shorter than refresh cycle time");
    a_zq_window: assert property (cmd_i.valid && cmd_i.op == CMD_ZQS &&
        !r.pattern_en ##1 (!(cmd_i.valid && cmd_i.op == CMD_ZQS))[*8]
        |-> ##55 zq_busy_o)
        else $error("short calibration ended early");
    a_low_power_gate: assert property (low_power_o |->
        !$past(refresh_busy_o) && !$past(zq_busy_o))
        else $error("low power while work in progress");

endmodule // ddr3_calibration_pattern_readout

`default_nettype wire

// [bench/pattern_capture_model.sv]
// Controller-side capture of pattern bursts on the link clock.
// Assumes dq/strobe are registered on clk_link_i by the device.
`timescale 1ns/1ps
`default_nettype none

module pattern_capture_model (
    input wire logic clk_link_i,
    input wire logic [15:0] dq_i,
    input wire logic dq_oe_i,
    input wire logic strobe_i,
    input wire logic strobe_oe_i,
    output logic [7:0] bits_o,
    output logic [3:0] beats_o,
    output logic lanes_ok_o,
    output logic [7:0] burst_cnt_o
);
    // ======================================================================
    // Capture; no reset pin, so start values come from declarations and the initial block
    logic [7:0] acc = 8'h00;
    logic [3:0] n = 4'h0;
    logic ok = 1'b1;
    logic prev_oe = 1'b0;
    logic exp_strobe = 1'b1;
    initial begin
        bits_o = 8'h00;
        beats_o = 4'h0;
        lanes_ok_o = 1'b1;
        burst_cnt_o = 8'h00;
    end
    always @(posedge clk_link_i) begin
        if (dq_oe_i === 1'b1) begin
            acc[n[2:0]] <= dq_i[0];
            n <= n + 4'h1;
            // All lines of both lanes copy bit 0; strobe toggles from 1
            if (dq_i !== {16{dq_i[0]}} || strobe_oe_i !== 1'b1 ||
                strobe_i !== exp_strobe) begin
                ok <= 1'b0;
            end
            exp_strobe <= ~exp_strobe;
        end else if (prev_oe) begin
            // Burst end marks the start of read recovery
            bits_o <= acc;
            beats_o <= n;
            lanes_ok_o <= ok;
            burst_cnt_o <= burst_cnt_o + 8'h01;
            acc <= 8'h00;
            n <= 4'h0;
            ok <= 1'b1;
            exp_strobe <= 1'b1;
        end
        prev_oe <= dq_oe_i;
    end
endmodule // pattern_capture_model

`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the pattern readout block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import pattern_readout_pkg::*;
    // ======================================================================
    // Clocks, stimulus, monitor
    logic clk_sys_i = 1'b0, clk_link_i = 1'b0, sys_rst_i = 1'b1, cke_i = 1'b1;
    cmd_t cmd_i = '0;
    logic [4:0] wl = 5'h05;
    burst_mode_t burst_mode_i = BURST_FIXED_EIGHT;
    logic pm, ard, awr, pre, wst, ill, refu, rbusy, zbusy, lp;
    logic [1:0] loc;
    logic [15:0] dq;
    logic dq_oe, stb, stb_oe, lanes_ok;
    logic [7:0] bits, bcnt;
    logic [3:0] beats;
    logic s_rd, s_wr, s_pre, s_ill, lp_bad, s_refu;
    int n_ref, n_zq, cyc, t_wr, t_ws, error_cnt = 0, total_checks = 0;
    int seed = 32'hafe9ff0d;

    always #12.5 clk_sys_i = ~clk_sys_i;
    initial begin
        #1.3; // Link clock phase unrelated to system clock
        forever #3 clk_link_i = ~clk_link_i;
    end

    ddr3_calibration_pattern_readout i_ddr3_calibration_pattern_readout (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .clk_link_i(clk_link_i), .cmd_i(cmd_i), .cke_i(cke_i),
        .write_latency_cycles_i(wl), .burst_mode_i(burst_mode_i),
        .pattern_mode_o(pm), .pattern_location_select_o(loc),
        .array_read_o(ard), .array_write_o(awr), .precharge_o(pre),
        .write_start_o(wst), .cmd_illegal_o(ill), .read_refused_o(refu),
        .refresh_busy_o(rbusy), .zq_busy_o(zbusy), .low_power_o(lp),
        .dq_o(dq), .dq_oe_o(dq_oe), .strobe_o(stb), .strobe_oe_o(stb_oe));

    pattern_capture_model i_pattern_capture_model (
        .clk_link_i(clk_link_i), .dq_i(dq), .dq_oe_i(dq_oe),
        .strobe_i(stb), .strobe_oe_i(stb_oe), .bits_o(bits),
        .beats_o(beats), .lanes_ok_o(lanes_ok), .burst_cnt_o(bcnt));

    // Sticky flags so the one-cycle pulses cannot be missed
    always @(posedge clk_sys_i) begin
        cyc++;
        if (ard === 1'b1) s_rd = 1'b1;
        if (awr === 1'b1) begin s_wr = 1'b1; t_wr = cyc; end
        if (pre === 1'b1) s_pre = 1'b1;
        if (ill === 1'b1) s_ill = 1'b1;
        if (refu === 1'b1) s_refu = 1'b1;
        if (wst === 1'b1) t_ws = cyc;
        if (rbusy === 1'b1) n_ref++;
        if (zbusy === 1'b1) n_zq++;
        if (lp === 1'b1 && rbusy === 1'b1) lp_bad = 1'b1;
    end

    // ======================================================================
    // Tasks and expectations
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic issue(input cmd_op_t op, input logic [2:0] b,
                         input logic [13:0] a);
        @(posedge clk_sys_i);
        #1;
        cmd_i = {1'b1, op, b, a};
        {s_rd, s_wr, s_pre, s_ill, lp_bad, s_refu} = '0;
        {n_ref, n_zq, t_wr, t_ws} = '0;
        @(posedge clk_sys_i);
        #1;
        cmd_i.valid = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic reset_dut();
        @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
    endtask

    // Location 0 alternates 0,1 from beat 0; other locations read zero
    function automatic logic [7:0] exp_bits(input logic [1:0] l,
                                            input logic chop);
        if (l != 2'h0) return 8'h00;
        return chop ? 8'h0a : 8'haa;
    endfunction

    function automatic logic [15:0] exp_gap(input logic [4:0] w,
                                            input burst_mode_t m);
        return (m == BURST_FIXED_CHOP) ? 16'(w) + 16'h1 : 16'(w) + 16'h3;
    endfunction

    task automatic pattern_read(input logic [1:0] l);
        logic [7:0] c0;
        logic chop, a12, a2;
        burst_mode_t m;
        m = burst_mode_t'(2'($unsigned($random(seed)) % 3));
        a12 = 1'($random(seed));
        a2 = 1'($random(seed));
        chop = (m == BURST_FIXED_CHOP) || (m == BURST_ON_THE_FLY && !a12);
        burst_mode_i = m;
        c0 = bcnt;
        // Auto-precharge bit set at random; it must change nothing
        issue(CMD_RD, 3'($random(seed)),
              {1'b0, a12, 1'b0, 1'($random(seed)), 7'h00, a2, 2'h0});
        for (int k = 0; k < 100 && bcnt == c0; k++) @(posedge clk_sys_i);
        repeat (10) @(posedge clk_sys_i); // Read recovery before next MRS
        #1;
        chk(s_rd, 1'b0);
        chk(s_refu, 1'b0);
        chk(s_pre, 1'b0);
        chk(bcnt, c0 + 8'h01);
        chk(bits, exp_bits(l, chop));
        chk(beats, chop ? 4'h4 : 4'h8);
        chk(lanes_ok, 1'b1);
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        sys_rst_i = 1'b0;
        chk(pm, 1'b0);
        issue(CMD_RD, 3'h1, 14'h0400);
        chk({s_rd, s_pre}, 2'b11);
        $display("test normal read done");
        for (int i = 0; i < 8; i++) begin
            wl = 5'($unsigned($random(seed)) % 16) + 5'h1;
            burst_mode_i = burst_mode_t'(2'($unsigned($random(seed)) % 3));
            issue(CMD_WR, 3'h2, {1'b0, 1'($random(seed)), 12'h000});
            repeat (24) @(posedge clk_sys_i);
            chk(s_wr, 1'b1);
            chk(16'(t_ws - t_wr), exp_gap(wl, burst_mode_i));
        end
        $display("test write start done");
        issue(CMD_REF, 3'h0, 14'h0000);
        cke_i = 1'b0; // Lowered while refresh still busy
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(16'(n_ref), 16'h5);
        chk({lp_bad, lp}, 2'b01);
        cke_i = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        issue(CMD_ZQS, 3'h0, 14'h0000);
        repeat (70) @(posedge clk_sys_i);
        chk(16'(n_zq), 16'd64);
        $display("test refresh and calibration done");
        issue(CMD_PRE, 3'h0, 14'h0400); // All banks idle first
        repeat (5) @(posedge clk_sys_i);
        for (int l = 0; l < 4; l++) begin
            issue(CMD_MRS, 3'h3, 14'h0004 | 14'(l));
            chk({pm, loc}, {1'b1, 2'(l)});
            for (int k = 0; k < 3; k++) pattern_read(2'(l));
        end
        $display("test pattern reads done");
        // Forbidden commands on purpose; each must be ignored
        for (int i = 0; i < 6; i++) begin
            // Skip the read code: reads and MR3 writes stay legal here
            issue(i == 5 ? CMD_MRS : cmd_op_t'(i < 3 ? 3'h2 + 3'(i) :
                  3'h3 + 3'(i)), 3'h0, 14'h0000);
            chk({s_ill, s_wr, pm}, 3'b101);
        end
        s_ill = 1'b0;
        cke_i = 1'b0; // Power-down attempt while patterns are on
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk({s_ill, lp, pm}, 3'b101);
        cke_i = 1'b1;
        $display("test forbidden commands done");
        reset_dut();
        repeat (3) @(posedge clk_sys_i);
        chk(pm, 1'b0);
        issue(CMD_MRS, 3'h3, 14'h0004);
        // Back-to-back reads: the second finds the burst still pending
        @(posedge clk_sys_i);
        #1;
        cmd_i = {1'b1, CMD_RD, 3'h0, 14'h0000};
        repeat (2) @(posedge clk_sys_i);
        #1;
        cmd_i.valid = 1'b0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        chk({s_refu, s_rd}, 2'b10);
        issue(CMD_MRS, 3'h3, 14'($random(seed)) & 14'h0003);
        chk(pm, 1'b0);
        issue(CMD_RD, 3'h0, 14'h0000);
        chk(s_rd, 1'b1);
        $display("test reset and exit done");
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
